// ===== verilog/intc_vec_pkg.sv
// Purpose: Constants for the interrupt vector generation block
// Assumes: 40 sources, 32 priority levels, 7-bit vector
// Notes:   Register offsets are word indexes on the plain register port
package intc_vec_pkg;
    localparam int NUM_SRC     = 40;
    localparam int NUM_LVL     = 32;
    localparam int LVL_W       = 5;
    localparam int VEC_W       = 7;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    // Register map
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_FAST_EN0 = 8'h01;
    localparam logic [7:0] OFS_FAST_EN1 = 8'h02;
    localparam logic [7:0] OFS_NORM_EN0 = 8'h03;
    localparam logic [7:0] OFS_NORM_EN1 = 8'h04;
    localparam logic [7:0] OFS_FAST_PND = 8'h05;
    localparam logic [7:0] OFS_NORM_PND = 8'h06;
    localparam logic [7:0] OFS_STATUS   = 8'h07;
    localparam logic [7:0] OFS_SRC_RAW0 = 8'h08;
    localparam logic [7:0] OFS_SRC_RAW1 = 8'h09;
    localparam logic [7:0] OFS_LVL_BASE = 8'h40;
    // Control fields
    localparam int CTRL_AUTOVEC_BIT   = 0;
    localparam int CTRL_SEPFAST_BIT   = 1;
    localparam logic CTRL_AUTOVEC_RST = 1'b1;
    localparam logic CTRL_SEPFAST_RST = 1'b0;
    localparam logic [4:0] LVL_RST = 5'h00;
    // Status fields
    localparam int STAT_VEC_LSB  = 0;
    localparam int STAT_FAST_BIT = 8;
    localparam int STAT_NORM_BIT = 9;
    localparam int STAT_AUTO_BIT = 10;
    // Vector upper bits
    localparam logic [1:0] VEC_HI_NORM = 2'h1;
    localparam logic [1:0] VEC_HI_FAST = 2'h2;
    // Source assignment
    localparam int SRC_ADC_Q1_PAUSE = 0;
    localparam int SRC_ADC_Q2_DONE  = 3;
    localparam int SRC_SPI_FAULT    = 4;
    localparam int SRC_SPI_DONE     = 5;
    localparam int SRC_UART1_FIRST  = 6;
    localparam int SRC_UART2_FIRST  = 11;
    localparam int SRC_TIMER1_FIRST = 16;
    localparam int SRC_TIMER2_FIRST = 23;
    localparam int SRC_TICK1        = 30;
    localparam int SRC_TICK2        = 31;
    localparam int SRC_EDGE_FIRST   = 32;
    localparam int UART_FLAGS       = 5;
    localparam int TIMER_FLAGS      = 7;
    localparam int EDGE_FLAGS       = 8;
    localparam int ADC_FLAGS        = 4;
endpackage

// ===== verilog/lvl_mem.sv
// Purpose: Priority level store, one 5-bit level per source
// Assumes: One write and one read port, synchronous read
// Notes:   Also exposes all levels flat for the pending logic
`timescale 1ns/1ps
module lvl_mem
    import intc_vec_pkg::*;
#(
    parameter int DEPTH = NUM_SRC
) (
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_i,
    input  wire logic                     wr_en_i,
    input  wire logic [5:0]               wr_idx_i,
    input  wire logic [LVL_W-1:0]         wr_data_i,
    input  wire logic [5:0]               rd_idx_i,
    output logic      [LVL_W-1:0]         rd_data_o,
    output logic      [DEPTH*LVL_W-1:0]   all_lvl_o
);
    logic [LVL_W-1:0] mem_r [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    mem_r[g] <= LVL_RST;
                end else if (wr_en_i && wr_idx_i == 6'(g)) begin
                    mem_r[g] <= wr_data_i;
                end
            end
            assign all_lvl_o[g*LVL_W +: LVL_W] = mem_r[g];
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rd_data_o <= '0;
        end else if (rd_idx_i < 6'(DEPTH)) begin
            rd_data_o <= mem_r[rd_idx_i];
        end else begin
            rd_data_o <= '0;
        end
    end
endmodule

// ===== verilog/prio_enc.sv
// Purpose: 32-to-5 priority encoder, highest set bit wins
// Assumes: Level 31 is the highest priority
// Notes:   Pure combinational
`timescale 1ns/1ps
module prio_enc
    import intc_vec_pkg::*;
(
    input  wire logic [NUM_LVL-1:0] req_i,
    output logic                    any_o,
    output logic      [LVL_W-1:0]   lvl_o
);
    always_comb begin
        lvl_o = '0;
        any_o = |req_i;
        for (int i = 0; i < NUM_LVL; i++) begin
            if (req_i[i]) begin
                lvl_o = LVL_W'(i);
            end
        end
    end
endmodule

// ===== verilog/intc_vec_gen.sv
// Purpose: Vector number generation for a 40-source prioritised interrupt controller
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Requests are levels held by the peripherals until cleared there
//
// Behaviour
// - Vectored mode presents explicit vector number
// - Low bits: highest level, fast class first
// - Upper bits 01 normal, 10 separate fast
// - Shared vectors land in 32 to 63
// - Separate fast vectors land in 64 to 95
// - Lowest level gives lowest vector number
// - Reset: sources disabled, level zero
// - Levels, enables and options software programmable
// - Sources 0-3 converter queue flags
// - Sources 4-5 serial fault and done
// - Sources 6-15 two asynchronous serial ports
// - Sources 16-29 two timers' flags
// - Sources 30-31 periodic timer flags
// - Sources 32-39 edge port flags
// - Autovector enable resets to one
// - Vector and request outputs registered
// - Fast request beats and negates normal
// - Level 31 highest, 0 lowest
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module intc_vec_gen
    import intc_vec_pkg::*;
#(
    parameter int SRC_N = NUM_SRC
) (
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic [ADC_FLAGS-1:0]   adc_req_i,
    input  wire logic                serial_mode_fault_flag_i,
    input  wire logic                serial_transfer_done_flag_i,
    input  wire logic [UART_FLAGS-1:0]  uart_one_req_i,
    input  wire logic [UART_FLAGS-1:0]  uart_two_req_i,
    input  wire logic [TIMER_FLAGS-1:0] timer_one_req_i,
    input  wire logic [TIMER_FLAGS-1:0] timer_two_req_i,
    input  wire logic                periodic_timer_one_flag_i,
    input  wire logic                periodic_timer_two_flag_i,
    input  wire logic [EDGE_FLAGS-1:0]  edge_detect_port_req_i,
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [DATA_W-1:0]   reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [DATA_W-1:0]   reg_rdata_o,
    output logic      [VEC_W-1:0]    vector_o,
    output logic                     fast_req_o,
    output logic                     norm_req_o,
    output logic                     autovector_o
);
    ////////////////////////////////////////////////////////////////////////
    // Source assembly
    logic [SRC_N-1:0] src_raw;
    always_comb begin
        src_raw = '0;
        src_raw[SRC_ADC_Q1_PAUSE +: ADC_FLAGS] = adc_req_i;
        src_raw[SRC_SPI_FAULT] = serial_mode_fault_flag_i;
        src_raw[SRC_SPI_DONE] = serial_transfer_done_flag_i;
        src_raw[SRC_UART1_FIRST +: UART_FLAGS] = uart_one_req_i;
        src_raw[SRC_UART2_FIRST +: UART_FLAGS] = uart_two_req_i;
        src_raw[SRC_TIMER1_FIRST +: TIMER_FLAGS] = timer_one_req_i;
        src_raw[SRC_TIMER2_FIRST +: TIMER_FLAGS] = timer_two_req_i;
        src_raw[SRC_TICK1] = periodic_timer_one_flag_i;
        src_raw[SRC_TICK2] = periodic_timer_two_flag_i;
        src_raw[SRC_EDGE_FIRST +: EDGE_FLAGS] = edge_detect_port_req_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic                autovector_enable_r;
    logic                separate_fast_vector_r;
    logic [SRC_N-1:0]    fast_en_r;
    logic [SRC_N-1:0]    norm_en_r;
    logic                lvl_wr;
    logic [5:0]          lvl_idx;
    logic [LVL_W-1:0]    lvl_rd;
    logic [SRC_N*LVL_W-1:0] all_lvl;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            autovector_enable_r    <= CTRL_AUTOVEC_RST;
            separate_fast_vector_r <= CTRL_SEPFAST_RST;
        end else if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
            autovector_enable_r    <= reg_wdata_i[CTRL_AUTOVEC_BIT];
            separate_fast_vector_r <= reg_wdata_i[CTRL_SEPFAST_BIT];
        end
    end

    // Source enables cleared at reset; upper words hold sources 32 and up
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            fast_en_r <= '0;
            norm_en_r <= '0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_FAST_EN0: fast_en_r[31:0] <= reg_wdata_i;
                OFS_FAST_EN1: fast_en_r[SRC_N-1:32] <= reg_wdata_i[SRC_N-33:0];
                OFS_NORM_EN0: norm_en_r[31:0] <= reg_wdata_i;
                OFS_NORM_EN1: norm_en_r[SRC_N-1:32] <= reg_wdata_i[SRC_N-33:0];
                default: ;
            endcase
        end
    end

    // Writes past the last source fall on no entry
    assign lvl_idx = 6'(reg_addr_i - OFS_LVL_BASE);
    assign lvl_wr  = reg_wr_i && reg_addr_i >= OFS_LVL_BASE
                     && reg_addr_i < OFS_LVL_BASE + 8'(SRC_N);

    lvl_mem #(.DEPTH(SRC_N)) u_lvl (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .wr_en_i    (lvl_wr),
        .wr_idx_i   (lvl_idx),
        .wr_data_i  (reg_wdata_i[LVL_W-1:0]),
        .rd_idx_i   (lvl_idx),
        .rd_data_o  (lvl_rd),
        .all_lvl_o  (all_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Per-level pending: a level is pending in a class when any source at it requests and is enabled for that class
    logic [NUM_LVL-1:0] fast_pnd;
    logic [NUM_LVL-1:0] norm_pnd;
    always_comb begin
        fast_pnd = '0;
        norm_pnd = '0;
        for (int s = 0; s < SRC_N; s++) begin
            if (src_raw[s] && fast_en_r[s]) begin
                fast_pnd[all_lvl[s*LVL_W +: LVL_W]] = 1'b1;
            end
            if (src_raw[s] && norm_en_r[s]) begin
                norm_pnd[all_lvl[s*LVL_W +: LVL_W]] = 1'b1;
            end
        end
    end

    logic             fast_any;
    logic             norm_any;
    logic [LVL_W-1:0] fast_lvl;
    logic [LVL_W-1:0] norm_lvl;

    prio_enc u_fast_enc (
        .req_i (fast_pnd),
        .any_o (fast_any),
        .lvl_o (fast_lvl)
    );

    prio_enc u_norm_enc (
        .req_i (norm_pnd),
        .any_o (norm_any),
        .lvl_o (norm_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Vector formation
    logic [VEC_W-1:0] vector_nxt;
    logic             fast_nxt;
    logic             norm_nxt;
    always_comb begin
        fast_nxt = fast_any;
        norm_nxt = norm_any && !fast_any;
        vector_nxt[4:0] = fast_any ? fast_lvl : norm_lvl;
        // Upper bits never 00 or 11, even when idle
        if (fast_any && separate_fast_vector_r) begin
            vector_nxt[6:5] = VEC_HI_FAST;
        end else begin
            vector_nxt[6:5] = VEC_HI_NORM;
        end
    end

    // One clock of latency toward the core
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            vector_o     <= {VEC_HI_NORM, LVL_RST};
            fast_req_o   <= 1'b0;
            norm_req_o   <= 1'b0;
            autovector_o <= CTRL_AUTOVEC_RST;
        end else begin
            vector_o     <= vector_nxt;
            fast_req_o   <= fast_nxt;
            norm_req_o   <= norm_nxt;
            autovector_o <= autovector_enable_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port; level store answers itself one cycle late
    logic [DATA_W-1:0] rdata_nxt;
    logic              lvl_rd_q;
    always_comb begin
        rdata_nxt = '0;
        case (reg_addr_i)
            OFS_CTRL: begin
                rdata_nxt[CTRL_AUTOVEC_BIT] = autovector_enable_r;
                rdata_nxt[CTRL_SEPFAST_BIT] = separate_fast_vector_r;
            end
            OFS_FAST_EN0: rdata_nxt = fast_en_r[31:0];
            OFS_FAST_EN1: rdata_nxt[SRC_N-33:0] = fast_en_r[SRC_N-1:32];
            OFS_NORM_EN0: rdata_nxt = norm_en_r[31:0];
            OFS_NORM_EN1: rdata_nxt[SRC_N-33:0] = norm_en_r[SRC_N-1:32];
            OFS_FAST_PND: rdata_nxt = fast_pnd;
            OFS_NORM_PND: rdata_nxt = norm_pnd;
            OFS_STATUS: begin
                rdata_nxt[STAT_VEC_LSB +: VEC_W] = vector_o;
                rdata_nxt[STAT_FAST_BIT] = fast_req_o;
                rdata_nxt[STAT_NORM_BIT] = norm_req_o;
                rdata_nxt[STAT_AUTO_BIT] = autovector_o;
            end
            OFS_SRC_RAW0: rdata_nxt = src_raw[31:0];
            OFS_SRC_RAW1: rdata_nxt[SRC_N-33:0] = src_raw[SRC_N-1:32];
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lvl_rd_q <= 1'b0;
        end else begin
            lvl_rd_q <= reg_rd_i && reg_addr_i >= OFS_LVL_BASE
                        && reg_addr_i < OFS_LVL_BASE + 8'(SRC_N);
        end
    end

    // Register mux; level reads patched in from the memory's output register
    logic [DATA_W-1:0] rdata_q;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= rdata_nxt;
        end else begin
            rdata_q <= '0;
        end
    end
    always_comb begin
        reg_rdata_o = lvl_rd_q ? {{(DATA_W-LVL_W){1'b0}}, lvl_rd} : rdata_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Class selection and one clock of latency
    a_fast_wins: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fast_req_o |-> !norm_req_o)
        else $error("normal request while fast asserted");
    a_fast_both: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (fast_any && norm_any) |=> !norm_req_o)
        else $error("normal request beside a fast one");
    a_preempt: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (norm_req_o && fast_any)
        |=> (fast_req_o && !norm_req_o))
        else $error("fast request did not negate normal");
    a_fast_lat: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fast_any |=> fast_req_o)
        else $error("fast request not registered");
    a_norm_lat: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (norm_any && !fast_any) |=> norm_req_o)
        else $error("normal request not registered");
    a_vec_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ($stable(fast_pnd) && $stable(norm_pnd) && $stable(separate_fast_vector_r))
        |=> $stable(vector_o))
        else $error("vector moved with steady inputs");
    a_idle_low: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!fast_any && !norm_any) |=> (!fast_req_o && !norm_req_o))
        else $error("request out while idle");
    a_fast_drop: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !fast_any |=> !fast_req_o)
        else $error("fast request with nothing pending");
    a_autovec_out: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> autovector_o == $past(autovector_enable_r))
        else $error("autovector output not registered");

    // Vector fields and ranges
    a_hi_legal: assert property (@(posedge core_clk_i) disable iff (reset_i)
        vector_o[6:5] == 2'h1 || vector_o[6:5] == 2'h2)
        else $error("illegal vector upper bits");
    a_norm_hi: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!fast_any || !separate_fast_vector_r) |=> vector_o[6:5] == VEC_HI_NORM)
        else $error("vector upper bits not 01");
    a_fast_range: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (fast_any && separate_fast_vector_r) |=> vector_o[6:5] == 2'h2)
        else $error("fast vector outside 64 to 95");
    a_shared_range: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !separate_fast_vector_r |=> vector_o[6:5] == 2'h1)
        else $error("shared vector outside 32 to 63");
    a_low_bits: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fast_any |=> vector_o[4:0] == $past(fast_lvl))
        else $error("vector low bits not fast level");
    a_norm_bits: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (norm_any && !fast_any) |=> vector_o[4:0] == $past(norm_lvl))
        else $error("vector low bits not normal level");
    a_top_level: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!fast_any && norm_pnd[31]) |=> vector_o[4:0] == 5'h1F)
        else $error("level 31 not chosen");
    a_top_fast: assert property (@(posedge core_clk_i) disable iff (reset_i)
        fast_pnd[31] |=> vector_o[4:0] == 5'h1F)
        else $error("fast level 31 not chosen");
    a_fast_lowest: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (fast_pnd == 32'h1 && separate_fast_vector_r)
        |=> vector_o == {VEC_HI_FAST, 5'h00})
        else $error("fast level 0 not vector 64");
    a_fast_top_vec: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (fast_pnd[31] && separate_fast_vector_r)
        |=> vector_o == {VEC_HI_FAST, 5'h1F})
        else $error("fast level 31 not vector 95");
    a_norm_lowest: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!fast_any && norm_pnd == 32'h1)
        |=> vector_o == {VEC_HI_NORM, 5'h00})
        else $error("normal level 0 not vector 32");
    a_norm_top_vec: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!fast_any && norm_pnd[31])
        |=> vector_o == {VEC_HI_NORM, 5'h1F})
        else $error("normal level 31 not vector 63");

    // Reset defaults
    a_autovec_reset: assert property (@(posedge core_clk_i)
        $fell(reset_i) |-> autovector_enable_r && fast_en_r == '0)
        else $error("reset defaults wrong");
    a_autovec_pin: assert property (@(posedge core_clk_i)
        $fell(reset_i) |-> autovector_o && !fast_req_o && !norm_req_o)
        else $error("reset outputs wrong");
    a_en_reset: assert property (@(posedge core_clk_i)
        $fell(reset_i)
        |-> norm_en_r == '0 && all_lvl == '0 && separate_fast_vector_r == CTRL_SEPFAST_RST)
        else $error("source enables or levels not cleared");

    // Main scenarios
    c_fast: cover property (@(posedge core_clk_i) disable iff (reset_i)
        fast_req_o && vector_o[6:5] == 2'h2);
    c_preempt: cover property (@(posedge core_clk_i) disable iff (reset_i)
        norm_req_o ##1 fast_req_o);
    c_vectored: cover property (@(posedge core_clk_i) disable iff (reset_i)
        !autovector_o && norm_req_o);
    c_fast_shared: cover property (@(posedge core_clk_i) disable iff (reset_i)
        fast_req_o && vector_o[6:5] == VEC_HI_NORM);
    c_fast_lowest: cover property (@(posedge core_clk_i) disable iff (reset_i)
        fast_req_o && vector_o == {VEC_HI_FAST, 5'h00});
endmodule

// ===== verification/periph_src_model.sv
// Purpose: Peripheral request sources that face the vector block
// Assumes: The bench commands each flag to be set or cleared
// Notes:   A clear command stands in for that peripheral's own flag-clear sequence
`timescale 1ns/1ps
module periph_src_model
    import intc_vec_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_i,
    input  wire logic [NUM_SRC-1:0]     set_i,
    input  wire logic [NUM_SRC-1:0]     clr_i,
    input  wire logic [NUM_SRC-1:0]     local_en_i,
    output logic      [ADC_FLAGS-1:0]   adc_req_o,
    output logic                        ser_fault_o,
    output logic                        ser_done_o,
    output logic      [UART_FLAGS-1:0]  uart1_req_o,
    output logic      [UART_FLAGS-1:0]  uart2_req_o,
    output logic      [TIMER_FLAGS-1:0] tmr1_req_o,
    output logic      [TIMER_FLAGS-1:0] tmr2_req_o,
    output logic                        tick1_req_o,
    output logic                        tick2_req_o,
    output logic      [EDGE_FLAGS-1:0]  edge_req_o
);
    logic [NUM_SRC-1:0] flag_r;
    logic [NUM_SRC-1:0] req;
    ////////////////////////////////////////////////////////////////////////////////
    // Flags hold until cleared, so a late clear keeps the request up
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r | (set_i & local_en_i)) & ~clr_i;
        end
    end
    // No request without the local enable
    assign req = flag_r & local_en_i;
    ////////////////////////////////////////////////////////////////////////////////
    assign adc_req_o   = req[3:0];
    assign ser_fault_o = req[4];
    assign ser_done_o  = req[5];
    assign uart1_req_o = req[10:6];
    assign uart2_req_o = req[15:11];
    assign tmr1_req_o  = req[22:16];
    assign tmr2_req_o  = req[29:23];
    assign tick1_req_o = req[30];
    assign tick2_req_o = req[31];
    assign edge_req_o  = req[39:32];
endmodule

// ===== verification/interrupt_vector_generation_tb_top.sv
// Purpose: Self-checking bench for the vector generation block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Idle vector value is not compared, the core ignores it
`timescale 1ns/1ps
module interrupt_vector_generation_tb_top
    import intc_vec_pkg::*;
();
    logic                   core_clk_i;
    logic                   reset_i;
    logic [ADDR_W-1:0]      reg_addr_i;
    logic [DATA_W-1:0]      reg_wdata_i;
    logic                   reg_wr_i;
    logic                   reg_rd_i;
    logic [DATA_W-1:0]      reg_rdata_o;
    logic [VEC_W-1:0]       vector_o;
    logic                   fast_req_o;
    logic                   norm_req_o;
    logic                   autovector_o;
    logic [NUM_SRC-1:0]     set_r;
    logic [NUM_SRC-1:0]     clr_r;
    logic [NUM_SRC-1:0]     loc_en_r;
    logic [ADC_FLAGS-1:0]   adc_req;
    logic                   ser_fault;
    logic                   ser_done;
    logic [UART_FLAGS-1:0]  uart1_req;
    logic [UART_FLAGS-1:0]  uart2_req;
    logic [TIMER_FLAGS-1:0] tmr1_req;
    logic [TIMER_FLAGS-1:0] tmr2_req;
    logic                   tick1_req;
    logic                   tick2_req;
    logic [EDGE_FLAGS-1:0]  edge_req;
    int                     n_fail;
    int                     checks_done;
    ////////////////////////////////////////////////////////////////////////////////
    periph_src_model SRC (.core_clk_i(core_clk_i), .reset_i(reset_i), .set_i(set_r),
        .clr_i(clr_r), .local_en_i(loc_en_r), .adc_req_o(adc_req), .ser_fault_o(ser_fault),
        .ser_done_o(ser_done), .uart1_req_o(uart1_req), .uart2_req_o(uart2_req),
        .tmr1_req_o(tmr1_req), .tmr2_req_o(tmr2_req), .tick1_req_o(tick1_req),
        .tick2_req_o(tick2_req), .edge_req_o(edge_req));
    intc_vec_gen DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .adc_req_i(adc_req),
        .serial_mode_fault_flag_i(ser_fault), .serial_transfer_done_flag_i(ser_done),
        .uart_one_req_i(uart1_req), .uart_two_req_i(uart2_req),
        .timer_one_req_i(tmr1_req), .timer_two_req_i(tmr2_req),
        .periodic_timer_one_flag_i(tick1_req), .periodic_timer_two_flag_i(tick2_req),
        .edge_detect_port_req_i(edge_req), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .vector_o(vector_o), .fast_req_o(fast_req_o),
        .norm_req_o(norm_req_o), .autovector_o(autovector_o));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk_val(reg_rdata_o, exp);
    endtask
    // Vector only compared while a request is up
    task automatic chk_out(input logic f, input logic n, input logic [6:0] v);
        chk_val({30'h0, fast_req_o, norm_req_o}, {30'h0, f, n});
        if (f || n) begin
            chk_val({25'h0, vector_o}, {25'h0, v});
        end
    endtask
    task automatic src_cmd(input logic up, input int s);
        @(posedge core_clk_i);
        if (up) begin
            set_r[s] <= 1'b1;
        end else begin
            clr_r[s] <= 1'b1;
        end
        @(posedge core_clk_i);
        set_r <= '0;
        clr_r <= '0;
        #1;
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int lvl;
        n_fail = 0;
        checks_done = 0;
        reset_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        set_r = '0;
        clr_r = '0;
        loc_en_r = '0;
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1;
        chk_val({31'h0, autovector_o}, 32'h1);
        chk_out(1'b0, 1'b0, 7'h00);
        chk_rd(OFS_CTRL, 32'h1);
        chk_rd(OFS_LVL_BASE + 8'h27, 32'h0);
        chk_rd(OFS_FAST_EN0, 32'h0);
        chk_rd(OFS_NORM_EN1, 32'h0);
        reg_wr(8'h30, 32'hFFFF_FFFF);
        chk_rd(8'h30, 32'h0);
        chk_rd(OFS_CTRL, 32'h1);
        $display("test reset_defaults done");
        for (int s = 0; s < NUM_SRC; s++) begin
            lvl = s % NUM_LVL;
            reg_wr(OFS_LVL_BASE + 8'(s), 32'(lvl));
            reg_wr(OFS_NORM_EN0, (s < 32) ? (32'h1 << s) : 32'h0);
            reg_wr(OFS_NORM_EN1, (s < 32) ? 32'h0 : (32'h1 << (s - 32)));
            loc_en_r[s] <= 1'b1;
            src_cmd(1'b1, s);
            chk_out(1'b0, 1'b0, 7'h00);
            @(posedge core_clk_i);
            #1;
            chk_out(1'b0, 1'b1, {VEC_HI_NORM, 5'(lvl)});
            src_cmd(1'b0, s);
            @(posedge core_clk_i);
            #1;
            chk_out(1'b0, 1'b0, 7'h00);
        end
        $display("test source_map done");
        reg_wr(OFS_NORM_EN0, 32'h4000_0080);
        reg_wr(OFS_NORM_EN1, 32'h0);
        reg_wr(OFS_FAST_EN1, 32'h1);
        reg_wr(OFS_LVL_BASE + 8'h1E, 32'h1F);
        reg_wr(OFS_LVL_BASE + 8'h07, 32'h14);
        reg_wr(OFS_LVL_BASE + 8'h20, 32'h02);
        src_cmd(1'b1, 30);
        src_cmd(1'b1, 7);
        settle();
        chk_out(1'b0, 1'b1, 7'h3F);
        chk_rd(OFS_NORM_PND, 32'h8010_0000);
        chk_rd(OFS_SRC_RAW0, 32'h4000_0080);
        chk_rd(OFS_NORM_EN0, 32'h4000_0080);
        src_cmd(1'b1, 32);
        settle();
        chk_out(1'b1, 1'b0, 7'h22);
        chk_rd(OFS_FAST_PND, 32'h0000_0004);
        chk_rd(OFS_SRC_RAW1, 32'h0000_0001);
        chk_rd(OFS_FAST_EN1, 32'h0000_0001);
        reg_wr(OFS_CTRL, 32'h2);
        settle();
        chk_out(1'b1, 1'b0, 7'h42);
        chk_val({31'h0, autovector_o}, 32'h0);
        reg_wr(OFS_LVL_BASE + 8'h20, 32'h00);
        settle();
        chk_out(1'b1, 1'b0, 7'h40);
        reg_wr(OFS_LVL_BASE + 8'h20, 32'h1F);
        settle();
        chk_out(1'b1, 1'b0, 7'h5F);
        chk_rd(OFS_STATUS, 32'h15F);
        src_cmd(1'b0, 32);
        settle();
        chk_out(1'b0, 1'b1, 7'h3F);
        src_cmd(1'b0, 30);
        settle();
        chk_out(1'b0, 1'b1, 7'h34);
        src_cmd(1'b0, 7);
        settle();
        chk_out(1'b0, 1'b0, 7'h00);
        $display("test fast_priority done");
        end_sim();
    end
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule
